// [core/cdg_phase_gen.sv]
// shared constants and the two-phase processor clock generator.
// assumes one free-running system clock; the derived clocks leave as
// levels and the main block uses the one-cycle rise strobes.
package cdg_pkg;
  localparam int          SYS_PERIOD_NS  = 10;
  localparam int          IN_CLK_MHZ     = 20;  // doubled processor rate
  localparam int          CPU_PERIOD_NS  = 2 * 1000 / IN_CLK_MHZ;
  // quarter processor period = half an input clock period, rounded down
  localparam int          STEP_CYCLES    = CPU_PERIOD_NS / 4 / SYS_PERIOD_NS;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STRAP      = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_ACKCNT     = 8'h0c;
  localparam int          CTRL_GATE_WE   = 0;  // 1: write line gating
  localparam int          CTRL_FAST      = 1;  // 1: faster grade timing
  localparam int          STRAP_WAIT     = 0;
  localparam int          STRAP_FS_LO    = 1;
  localparam int          STRAP_FS_HI    = 2;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [2:0]  STRAP_RESET    = 3'h6;  // wait 0, both freq 1
  localparam int          ST_ALE         = 0;
  localparam int          ST_ACK_N       = 1;
  localparam int          ST_READY       = 2;
  localparam int          ST_CPU_CLK     = 3;
  localparam int          ST_PHASE_CLK   = 4;
endpackage : cdg_pkg

`timescale 1ns/1ns
module cdg_phase_gen #(
  parameter int STEPS = cdg_pkg::STEP_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output logic      cpuClk,
  output logic      phaseClk,
  output logic      cpuRise,
  output logic      phaseRise
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] john;  // johnson pair: bit0 main clock, bit1 lagging phase
  } cdg_pg_s;
  cdg_pg_s st_q, st_d;

  // each step is half an input period, so bit1 trails bit0 by 90 degrees
  always_comb begin
    st_d = st_q;
    if (st_q.cnt == 8'(STEPS - 1)) begin
      st_d.cnt  = 8'h00;
      st_d.john = {st_q.john[0], ~st_q.john[1]};
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cpuClk    = st_q.john[0];
  assign phaseClk  = st_q.john[1];
  assign cpuRise   = !st_q.john[0] && st_d.john[0];
  assign phaseRise = !st_q.john[1] && st_d.john[1];

  property p_phaseLag;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(cpuClk) |-> !phaseClk ##2 $rose(phaseClk);
  endproperty
  a_phaseLag: assert property (p_phaseLag)
    else $error("phase clock does not lag main clock by one step");

  property p_quarter;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(phaseClk) |-> cpuClk;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("phase clock rose outside main clock high half");

  c_phaseRise: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(phaseClk));
endmodule : cdg_phase_gen

// [core/cdg_glue.sv]
// processor to dram controller glue: byte write gating, two-phase clock,
// address latch enable, transfer acknowledge and strap outputs.
// assumes bus pins are asynchronous to sys_clk and an ahb-lite master.
//
// Contract
// - column strobe gated by each byte strobe gives early write per lane
// - write line gated by each byte strobe gives late write per lane
// - faster grades get main clock plus phase clock a quarter apart
// - both clocks from doubled-rate input; phase lags half input period
// - latch enable and acknowledge falls timed by phase clock
// - latch enable low on first phase rise after address strobe low
// - faster grades: controller no waits, acknowledge delayed outside
// - two waits: controller strapped one wait, external delay kept
// - acknowledge is AND of strobes and write line, OR latched ready
// - low ready holds acknowledge off until a period after refresh
// - faster grade acknowledge passes one more flip-flop stage
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module cdg_glue (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        addr_strobe_n,
  input  wire logic        upper_byte_strobe_n,
  input  wire logic        lower_byte_strobe_n,
  input  wire logic        cpuReadWrite,
  input  wire logic        colStrobeIn_n,
  input  wire logic        ctrlReady,
  output logic             cpuClk,
  output logic             phaseClk,
  output logic             addrLatchEn,
  output logic             transfer_ack_n,
  output logic             colStrobeUpper_n,
  output logic             colStrobeLower_n,
  output logic             writeUpper_n,
  output logic             writeLower_n,
  output logic             wait_select_strap,
  output logic             freq_select_hi,
  output logic             freq_select_lo
);
  // pin order in the synchroniser: as, uds, lds, rw, cas, ready
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic        ale;
    logic        ackRaw_n;
    logic        ack_n;
    logic        readyLat;
    logic        casU_n;
    logic        casL_n;
    logic        weU_n;
    logic        weL_n;
    logic [1:0]  ctrl;
    logic [2:0]  strap;
    logic [15:0] ackCnt;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] rdata;
  } cdg_st_s;
  cdg_st_s st_q, st_d;

  logic cpuRise;
  logic phaseRise;
  logic asN, udsN, ldsN, rw, casN, rdy;
  logic gateWe, fast, ackGate_n;
  logic [31:0] rdMux;

  cdg_phase_gen #(
    .STEPS (cdg_pkg::STEP_CYCLES)
  ) u_phase (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .cpuClk    (cpuClk),
    .phaseClk  (phaseClk),
    .cpuRise   (cpuRise),
    .phaseRise (phaseRise)
  );

  // only the second synchroniser stage is read
  assign {asN, udsN, ldsN, rw, casN, rdy} = st_q.sync2;
  assign gateWe = st_q.ctrl[cdg_pkg::CTRL_GATE_WE];
  assign fast   = st_q.ctrl[cdg_pkg::CTRL_FAST];
  // strobes on reads, write line on writes; stale ready blocks it
  assign ackGate_n = (udsN & ldsN & rw) | !st_q.readyLat;

  // register read mux, unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      cdg_pkg::OFS_CTRL:   rdMux = {30'h0, st_q.ctrl};
      cdg_pkg::OFS_STRAP:  rdMux = {29'h0, st_q.strap};
      cdg_pkg::OFS_STATUS: rdMux = {27'h0, phaseClk, cpuClk, st_q.readyLat,
                                    st_q.ack_n, st_q.ale};
      cdg_pkg::OFS_ACKCNT: rdMux = {16'h0, st_q.ackCnt};
      default:             rdMux = 32'h0000_0000;
    endcase
  end

  // all glue state advances here
  always_comb begin
    st_d = st_q;
    st_d.sync1 = {addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
                  cpuReadWrite, colStrobeIn_n, ctrlReady};
    st_d.sync2 = st_q.sync1;
    // byte lane write control, one form chosen by software
    if (!gateWe) begin
      st_d.casU_n = casN | udsN;
      st_d.casL_n = casN | ldsN;
      st_d.weU_n  = rw;
      st_d.weL_n  = rw;
    end else begin
      st_d.casU_n = casN;
      st_d.casL_n = casN;
      st_d.weU_n  = rw | udsN;
      st_d.weL_n  = rw | ldsN;
    end
    // ready sampled once per processor clock: holds ack a period longer
    if (cpuRise) begin
      st_d.readyLat = rdy;
    end
    // latch enable rises with the strobe, falls on a phase edge when fast
    if (asN) begin
      st_d.ale = 1'b1;
    end else if (!fast || phaseRise) begin
      st_d.ale = 1'b0;
    end
    // slow grade follows the gate; fast grade adds a phase-clocked stage
    if (!fast) begin
      st_d.ackRaw_n = ackGate_n;
      st_d.ack_n    = ackGate_n;
    end else if (phaseRise) begin
      st_d.ackRaw_n = ackGate_n;
      st_d.ack_n    = st_q.ackRaw_n;
    end
    if (st_q.ack_n && !st_d.ack_n) begin
      st_d.ackCnt = st_q.ackCnt + 16'h0001;
    end
    // ahb-lite: zero-wait slave, writes land in the data phase
    st_d.wrPend = 1'b0;
    if (st_q.wrPend) begin
      if (st_q.wrAddr == cdg_pkg::OFS_CTRL) begin
        st_d.ctrl = hwdata[1:0];
      end else if (st_q.wrAddr == cdg_pkg::OFS_STRAP) begin
        st_d.strap = hwdata[2:0];
      end
    end
    if (hsel && htrans[1] && hready) begin
      st_d.wrPend = hwrite;
      st_d.wrAddr = haddr[7:0];
      if (!hwrite) begin
        st_d.rdata = rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q          <= '0;
      st_q.sync1    <= 6'h3f;
      st_q.sync2    <= 6'h3f;
      st_q.ale      <= 1'b1;
      st_q.ackRaw_n <= 1'b1;
      st_q.ack_n    <= 1'b1;
      st_q.casU_n   <= 1'b1;
      st_q.casL_n   <= 1'b1;
      st_q.weU_n    <= 1'b1;
      st_q.weL_n    <= 1'b1;
      st_q.ctrl     <= cdg_pkg::CTRL_RESET;
      st_q.strap    <= cdg_pkg::STRAP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_q.rdata;
  assign addrLatchEn       = st_q.ale;
  assign transfer_ack_n    = st_q.ack_n;
  assign colStrobeUpper_n  = st_q.casU_n;
  assign colStrobeLower_n  = st_q.casL_n;
  assign writeUpper_n      = st_q.weU_n;
  assign writeLower_n      = st_q.weL_n;
  assign wait_select_strap = st_q.strap[cdg_pkg::STRAP_WAIT];
  assign freq_select_hi    = st_q.strap[cdg_pkg::STRAP_FS_HI];
  assign freq_select_lo    = st_q.strap[cdg_pkg::STRAP_FS_LO];

  property p_casGate;
    @(posedge sys_clk) disable iff (sys_rst)
      (!gateWe && udsN && !st_q.wrPend) |=>
        colStrobeUpper_n && ((!writeUpper_n) == (!$past(rw)));
  endproperty
  a_casGate: assert property (p_casGate)
    else $error("upper column strobe passed while byte strobe high");

  property p_weGate;
    @(posedge sys_clk) disable iff (sys_rst)
      (gateWe && !st_q.wrPend && (ldsN || rw)) |=> writeLower_n;
  endproperty
  a_weGate: assert property (p_weGate)
    else $error("lower write line low without strobe and write");

  property p_aleFall;
    @(posedge sys_clk) disable iff (sys_rst)
      (fast && $past(fast) && $fell(addrLatchEn)) |-> $past(phaseRise);
  endproperty
  a_aleFall: assert property (p_aleFall)
    else $error("latch enable fell off a phase edge");

  property p_aleFirst;
    @(posedge sys_clk) disable iff (sys_rst)
      (fast && !asN && addrLatchEn && phaseRise && !$past(st_q.wrPend))
        |=> !addrLatchEn;
  endproperty
  a_aleFirst: assert property (p_aleFirst)
    else $error("latch enable missed first phase rise");

  property p_ackDelay;
    @(posedge sys_clk) disable iff (sys_rst)
      (fast && $past(fast) && $changed(transfer_ack_n)) |-> $past(phaseRise);
  endproperty
  a_ackDelay: assert property (p_ackDelay)
    else $error("fast acknowledge moved off a phase edge");

  property p_ackReady;
    @(posedge sys_clk) disable iff (sys_rst)
      (!fast && !st_q.readyLat && !st_q.ctrl[1]) |=> transfer_ack_n;
  endproperty
  a_ackReady: assert property (p_ackReady)
    else $error("acknowledge given while ready latched low");

  property p_ackGate;
    @(posedge sys_clk) disable iff (sys_rst)
      (!fast && $past(!fast) && !udsN && st_q.readyLat && !st_q.wrPend)
        |=> !transfer_ack_n;
  endproperty
  a_ackGate: assert property (p_ackGate)
    else $error("acknowledge missing with strobe low and ready");

  property p_busOk;
    @(posedge sys_clk) disable iff (sys_rst)
      hreadyout && !hresp;
  endproperty
  a_busOk: assert property (p_busOk)
    else $error("bus slave not ready or not okay");

  property p_strapOut;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(st_q.wrPend) ##1 (st_q.wrAddr == cdg_pkg::OFS_STRAP) |->
        wait_select_strap == $past(hwdata[0]);
  endproperty
  a_strapOut: assert property (p_strapOut)
    else $error("strap output did not follow register write");

  c_fastAck: cover property (@(posedge sys_clk) disable iff (sys_rst)
    fast && $fell(transfer_ack_n));
  c_weMode: cover property (@(posedge sys_clk) disable iff (sys_rst)
    gateWe && $fell(writeUpper_n));
  c_casMode: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !gateWe && $fell(colStrobeLower_n));
endmodule : cdg_glue

// [dv/cdg_dram_model.sv]
// behavioural dram controller facing the glue: column strobe and ready.
// assumes the glue's strap pins and latch enable; refresh on request.
`timescale 1ns/1ns
module cdg_dram_model #(
  // longer than a processor period plus sync, so the ready latch sees it
  parameter int REFRESH_CYCLES = 24
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic addrLatchEn,
  input  wire logic wait_select_strap,
  input  wire logic freq_select_hi,
  input  wire logic freq_select_lo,
  input  wire logic refreshReq,
  output logic      colStrobeIn_n,
  output logic      ctrlReady
);
  int casCount;
  int refCount;
  // column strobe after latch enable low; strap adds one wait cycle
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      casCount      <= 0;
      refCount      <= 0;
      colStrobeIn_n <= 1'b1;
      ctrlReady     <= 1'b1;
    end else begin
      casCount <= addrLatchEn ? 0 : casCount + 1;
      // no waits unless strapped for one
      colStrobeIn_n <= !(!addrLatchEn && casCount >= 1 + wait_select_strap);
      // ready low while a refresh runs, so the access has to wait
      if (refreshReq)
        refCount <= REFRESH_CYCLES;
      else if (refCount > 0)
        refCount <= refCount - 1;
      ctrlReady <= !(refreshReq || refCount > 1);
    end
  end
endmodule : cdg_dram_model

// [dv/tb_top.sv]
// self-checking bench for the glue: ahb register access, lane gating,
// acknowledge, refresh hold-off, two-phase clocks and strap outputs.
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, refreshReq = 1'b0;
  logic addr_strobe_n = 1'b1, upper_byte_strobe_n = 1'b1;
  logic lower_byte_strobe_n = 1'b1, cpuReadWrite = 1'b1;
  logic colStrobeIn_n, ctrlReady, cpuClk, phaseClk, addrLatchEn;
  logic transfer_ack_n, colStrobeUpper_n, colStrobeLower_n;
  logic writeUpper_n, writeLower_n, wait_select_strap;
  logic freq_select_hi, freq_select_lo;
  int fail_count = 0, checks_done = 0, n, ns, nf;
  assign hready = hreadyout;  // single slave drives the bus ready
  always #5 sys_clk = ~sys_clk;
  cdg_glue dut (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .addr_strobe_n       (addr_strobe_n),
    .upper_byte_strobe_n (upper_byte_strobe_n),
    .lower_byte_strobe_n (lower_byte_strobe_n),
    .cpuReadWrite        (cpuReadWrite),
    .colStrobeIn_n       (colStrobeIn_n),
    .ctrlReady           (ctrlReady),
    .cpuClk              (cpuClk),
    .phaseClk            (phaseClk),
    .addrLatchEn         (addrLatchEn),
    .transfer_ack_n      (transfer_ack_n),
    .colStrobeUpper_n    (colStrobeUpper_n),
    .colStrobeLower_n    (colStrobeLower_n),
    .writeUpper_n        (writeUpper_n),
    .writeLower_n        (writeLower_n),
    .wait_select_strap   (wait_select_strap),
    .freq_select_hi      (freq_select_hi),
    .freq_select_lo      (freq_select_lo)
  );
  cdg_dram_model model (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .addrLatchEn       (addrLatchEn),
    .wait_select_strap (wait_select_strap),
    .freq_select_hi    (freq_select_hi),
    .freq_select_lo    (freq_select_lo),
    .refreshReq        (refreshReq),
    .colStrobeIn_n     (colStrobeIn_n),
    .ctrlReady         (ctrlReady)
  );

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  // one ahb-lite single word transfer; read data taken at the last edge
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
    check("hresp okay", hresp, 1'b0);
  endtask : ahb
  task automatic pins(input logic as, up, lo, rw);
    @(posedge sys_clk);
    addr_strobe_n       <= as;
    upper_byte_strobe_n <= up;
    lower_byte_strobe_n <= lo;
    cpuReadWrite        <= rw;
  endtask : pins
  task automatic idle();
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    // fast grade needs two phase edges plus sync before ack rises
    repeat (24) tick();
    check("ack idle", transfer_ack_n, 1'b1);
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic test_reset();
    check("ack reset", transfer_ack_n, 1'b1);
    check("strap pins", {wait_select_strap, freq_select_hi,
          freq_select_lo}, 3'h3);
    ahb(32'(cdg_pkg::OFS_CTRL), 1'b0, 32'h0, rd);
    check("ctrl reset", rd, 32'(cdg_pkg::CTRL_RESET));
    ahb(32'(cdg_pkg::OFS_STRAP), 1'b0, 32'h0, rd);
    check("strap reset", rd, 32'h6);
    ahb(32'h40, 1'b1, 32'hffffffff, rd);
    ahb(32'h40, 1'b0, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_col_gate();
    ahb(32'(cdg_pkg::OFS_CTRL), 1'b1, 32'h0, rd);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    n = 0;
    while (colStrobeUpper_n !== 1'b0 && n++ < 40) tick();
    check("col upper", colStrobeUpper_n, 1'b0);
    check("col lower", colStrobeLower_n, 1'b1);
    check("write ack", transfer_ack_n, 1'b0);
    idle();
    $display("test column gating done");
  endtask : test_col_gate
  task automatic test_we_gate();
    ahb(32'(cdg_pkg::OFS_CTRL), 1'b1, 32'h1, rd);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    n = 0;
    while (writeLower_n !== 1'b0 && n++ < 40) tick();
    check("we lower", writeLower_n, 1'b0);
    check("we upper", writeUpper_n, 1'b1);
    idle();
    $display("test write gating done");
  endtask : test_we_gate
  task automatic test_read_ack();
    ahb(32'(cdg_pkg::OFS_CTRL), 1'b1, 32'h0, rd);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    ns = 0;
    while (transfer_ack_n !== 1'b0 && ns++ < 40) tick();
    check("read ack", transfer_ack_n, 1'b0);
    idle();
    // refresh first, then the access: ack must stay off while ready is low
    @(posedge sys_clk);
    refreshReq <= 1'b1;
    @(posedge sys_clk);
    refreshReq <= 1'b0;
    // let the once-per-period ready latch see the low level
    repeat (12) @(posedge sys_clk);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    tick();
    while (ctrlReady === 1'b0) begin
      check("ack held", transfer_ack_n, 1'b1);
      tick();
    end
    check("ack held", transfer_ack_n, 1'b1);
    n = 0;
    while (transfer_ack_n !== 1'b0 && n++ < 40) tick();
    check("ack after refresh", transfer_ack_n, 1'b0);
    idle();
    $display("test acknowledge done");
  endtask : test_read_ack
  task automatic test_fast();
    ahb(32'(cdg_pkg::OFS_CTRL), 1'b1, 32'h2, rd);
    while (cpuClk !== 1'b0) tick();
    while (cpuClk !== 1'b1) tick();
    n = 0;
    while (phaseClk !== 1'b1 && n++ < 40) tick();
    check("phase lag", n, cdg_pkg::STEP_CYCLES);
    while (cpuClk !== 1'b0) begin
      n++;
      tick();
    end
    while (cpuClk !== 1'b1) begin
      n++;
      tick();
    end
    check("cpu period", n, 4 * cdg_pkg::STEP_CYCLES);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    n = 0;
    while (addrLatchEn !== 1'b0 && n++ < 40) tick();
    check("ale low", addrLatchEn, 1'b0);
    check("ale on phase", phaseClk, 1'b1);
    nf = 0;
    while (transfer_ack_n !== 1'b0 && nf++ < 60) tick();
    check("fast ack", transfer_ack_n, 1'b0);
    check("extra wait", nf + n > ns, 1'b1);
    // ack one processor period after the latch enable edge
    check("ack wait", nf, 4 * cdg_pkg::STEP_CYCLES);
    idle();
    $display("test fast grade done");
  endtask : test_fast
  task automatic test_two_wait();
    ahb(32'(cdg_pkg::OFS_STRAP), 1'b1, 32'h7, rd);
    ahb(32'(cdg_pkg::OFS_STRAP), 1'b0, 32'h0, rd);
    check("strap rb", rd, 32'h7);
    check("wait strap", wait_select_strap, 1'b1);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    n = 0;
    while (transfer_ack_n !== 1'b0 && n++ < 60) tick();
    check("two wait ack", transfer_ack_n, 1'b0);
    idle();
    // one ack fall each: column, write, read, refresh, fast, two waits
    ahb(32'(cdg_pkg::OFS_ACKCNT), 1'b0, 32'h0, rd);
    check("ack count", rd, 32'h6);
    // idle status: latch enable high, ack high, ready latched high
    ahb(32'(cdg_pkg::OFS_STATUS), 1'b0, 32'h0, rd);
    check("status idle", rd[2:0], 3'h7);
    $display("test two waits done");
  endtask : test_two_wait

  // watchdog: the whole sequence needs far fewer than 20000 cycles
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick();
    test_reset();
    test_col_gate();
    test_we_gate();
    test_read_ack();
    test_fast();
    test_two_wait();
    report_and_stop();
  end
endmodule : tb_top
